// *** ext_bus_pkg.sv ***
// shared constants and types for the external bus strobe controller
package ext_bus_pkg;

  // register indices and their byte addresses on the register bus
  localparam logic [7:0]  PORT0_INDEX    = 8'h80;
  localparam logic [7:0]  AUX_INDEX      = 8'h8E;
  localparam logic [11:0] PORT0_ADDR     = {2'b00, PORT0_INDEX, 2'b00};
  localparam logic [11:0] AUX_ADDR       = {2'b00, AUX_INDEX, 2'b00};

  // reset values
  localparam logic [7:0]  PORT0_RESET    = 8'hFF;
  localparam logic [1:0]  AUX_RESET      = 2'h0;

  // aux_function_control field positions
  localparam int          AUX_SUPPRESS_BIT = 0;
  localparam int          AUX_XRAM_BIT     = 1;
  localparam int          AUX_WIDTH        = 2;

  // machine cycle timing, in oscillator clocks
  localparam int          CLKS_PER_CYCLE = 6;
  localparam logic [2:0]  PH_LAST        = 3'(CLKS_PER_CYCLE - 1);
  localparam logic [2:0]  PH_ALE         = 3'h0;
  localparam logic [2:0]  PH_ADDR_END    = 3'h1;
  localparam logic [2:0]  PH_PROG_READ_STROBE_A      = 3'h2;
  localparam logic [2:0]  PH_PROG_READ_STROBE_B      = 3'h4;
  localparam logic [2:0]  PH_DATA_START  = 3'h2;
  localparam logic [2:0]  PH_DATA_END    = 3'h1;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_DATA
  } bus_state_type;

endpackage

// *** cycle_timing_if.sv ***
// machine cycle phase carried from the timer to the strobe logic
interface cycle_timing_if;
  logic [2:0] phase;
  logic       lastPhase;

  modport gen (
    output phase,
    output lastPhase
  );

  modport sink (
    input phase,
    input lastPhase
  );
endinterface

// *** machine_cycle_timer.sv ***
// six-clock machine cycle phase counter
module machine_cycle_timer (
  input wire logic  sys_clk,
  input wire logic  reset,
  cycle_timing_if.gen tim
);

  logic [2:0] phase_r;
  logic [2:0] phase_nxt;

  assign phase_nxt     = (phase_r == ext_bus_pkg::PH_LAST) ? 3'h0
                                                           : phase_r + 3'h1;
  assign tim.phase     = phase_r;
  assign tim.lastPhase = (phase_r == ext_bus_pkg::PH_LAST);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  a_cycle_wrap: assert property (
    @(posedge sys_clk) disable iff (reset)
    tim.lastPhase |=> (phase_r == 3'h0) [*1] ##5 tim.lastPhase)
    else $error("machine cycle is not six clocks long");

  a_cycle_count: assert property (
    @(posedge sys_clk) disable iff (reset)
    (phase_r != ext_bus_pkg::PH_LAST) |=> (phase_r == $past(phase_r) + 3'h1))
    else $error("phase did not advance by one");

endmodule

// *** ext_bus_strobe_ctrl.sv ***
// external memory bus strobe controller with APB register slave
//
// Overview of operation
// - address latch strobe pulses every machine cycle
// - one latch strobe dropped per data access
// - suppress bit limits latch strobe to data moves
// - program read strobe twice per machine cycle
// - two program read strobes dropped per access
// - no program read strobe on internal execution
// - select low fetches external, high internal
// - select level caught on first clock after reset, then frozen
// - read and write strobes low during access
// - reserved bits written zero, read as zero
// - fixed bits written and read as fixed
// - machine cycle lasts six clocks
// - port 0 multiplexes low address and data
// - port 2 carries high address byte
module ext_bus_strobe_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        extAccessSelect,
  input  wire logic [15:0] fetchAddr,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic        memWide,
  input  wire logic [15:0] memAddr,
  input  wire logic [7:0]  memWdata,
  output logic      [7:0]  memRdata,
  output logic             memAck,
  output logic             addrLatchStrobe,
  output logic             progReadStrobeN,
  output logic             rdStrobeN,
  output logic             wrStrobeN,
  output logic      [7:0]  port0Out,
  output logic      [7:0]  port0Oe,
  input  wire logic [7:0]  port0In,
  output logic      [7:0]  port2Out,
  output logic             extDataRamSelect,
  output logic             extExecActive
);

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle timing

  cycle_timing_if tIf ();

  machine_cycle_timer uTimer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tim     (tIf.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state and registers

  ext_bus_pkg::bus_state_type state_r;
  ext_bus_pkg::bus_state_type state_nxt;

  logic [7:0]  port0Latch_r;
  logic [ext_bus_pkg::AUX_WIDTH-1:0] aux_r;
  logic        extSel_r;
  logic        strapDone_r;
  logic        accWrite_r;
  logic        accWide_r;
  logic [15:0] accAddr_r;
  logic [7:0]  accWdata_r;
  logic        ale_r;
  logic        psenN_r;
  logic        rdN_r;
  logic        wrN_r;
  logic [7:0]  p0Out_r;
  logic [7:0]  p0Oe_r;
  logic [7:0]  p2Out_r;
  logic [7:0]  memRdata_r;
  logic        memAck_r;
  logic [31:0] prdata_r;

  function automatic logic regSel(input logic [11:0] a,
                                  input logic [11:0] target);
    regSel = (a == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle decode

  wire  [2:0] ph        = tIf.phase;
  wire        extExec   = strapDone_r & ~extSel_r;
  wire        inIdle    = (state_r == ext_bus_pkg::BUS_IDLE);
  wire        inAcc1    = (state_r == ext_bus_pkg::BUS_ADDR);
  wire        inAcc2    = (state_r == ext_bus_pkg::BUS_DATA);
  wire        suppress  = aux_r[ext_bus_pkg::AUX_SUPPRESS_BIT];
  wire        acceptReq = tIf.lastPhase & memReq & ~inAcc1;

  always_comb begin
    state_nxt = state_r;
    if (tIf.lastPhase) begin
      case (state_r)
        ext_bus_pkg::BUS_IDLE: state_nxt = acceptReq ? ext_bus_pkg::BUS_ADDR
                                                     : ext_bus_pkg::BUS_IDLE;
        ext_bus_pkg::BUS_ADDR: state_nxt = ext_bus_pkg::BUS_DATA;
        ext_bus_pkg::BUS_DATA: state_nxt = acceptReq ? ext_bus_pkg::BUS_ADDR
                                                     : ext_bus_pkg::BUS_IDLE;
        default:               state_nxt = ext_bus_pkg::BUS_IDLE;
      endcase
    end
  end

  // latch strobe: every cycle (address half only when suppressed), dropped in the data half of an access
  wire aleWant = (ph == ext_bus_pkg::PH_ALE)
               & (inAcc1 | (~suppress & ~inAcc2));

  // program read strobe twice a cycle, dropped while the access owns port 0
  wire psenWant = extExec & ~inAcc1
                & ((ph == ext_bus_pkg::PH_PROG_READ_STROBE_A)
                 | (ph == ext_bus_pkg::PH_PROG_READ_STROBE_B));

  wire dataWin = (inAcc1 & (ph >= ext_bus_pkg::PH_DATA_START))
               | (inAcc2 & (ph <= ext_bus_pkg::PH_DATA_END));
  wire rdWant  = dataWin & ~accWrite_r;
  wire wrWant  = dataWin & accWrite_r;

  wire dataAddrPh  = inAcc1 & (ph <= ext_bus_pkg::PH_ADDR_END);
  wire fetchAddrPh = extExec & inIdle & (ph <= ext_bus_pkg::PH_ADDR_END);
  wire busOwned    = extExec | ~inIdle;
  wire p0Drive     = dataAddrPh | fetchAddrPh | wrWant;

  // low address, then write data, on the multiplexed port
  wire [7:0] p0Out_nxt = dataAddrPh  ? accAddr_r[7:0] :
                         fetchAddrPh ? fetchAddr[7:0] :
                         wrWant      ? accWdata_r     : 8'h00;
  // latch drives open drain when the bus is not in use
  wire [7:0] p0Oe_nxt  = p0Drive  ? 8'hFF :
                         busOwned ? 8'h00 : ~port0Latch_r;
  wire [7:0] p2Out_nxt = (~inIdle & accWide_r) ? accAddr_r[15:8] :
                         (extExec & inIdle)    ? fetchAddr[15:8] :
                                                 8'hFF;

  wire readDone = inAcc2 & (ph == ext_bus_pkg::PH_DATA_END);

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  wire apbSetup  = psel & ~penable;
  wire apbAccess = psel & penable;
  wire hitPort0  = regSel(paddr, ext_bus_pkg::PORT0_ADDR);
  wire hitAux    = regSel(paddr, ext_bus_pkg::AUX_ADDR);
  wire apbWrite  = apbAccess & pwrite;

  // reserved aux bits are dropped on write and read back as zero
  wire [31:0] prdata_nxt = hitPort0 ? {24'h0, port0Latch_r} :
                           hitAux   ? {30'h0, aux_r}        : 32'h0;

  assign pready           = 1'b1;
  assign pslverr          = apbAccess & ~(hitPort0 | hitAux);
  assign prdata           = prdata_r;
  assign memRdata         = memRdata_r;
  assign memAck           = memAck_r;
  assign addrLatchStrobe  = ale_r;
  assign progReadStrobeN  = psenN_r;
  assign rdStrobeN        = rdN_r;
  assign wrStrobeN        = wrN_r;
  assign port0Out         = p0Out_r;
  assign port0Oe          = p0Oe_r;
  assign port2Out         = p2Out_r;
  assign extDataRamSelect = aux_r[ext_bus_pkg::AUX_XRAM_BIT];
  assign extExecActive    = extExec;

  ////////////////////////////////////////////////////////////////////////////
  // flip-flops

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      port0Latch_r <= ext_bus_pkg::PORT0_RESET;
      aux_r        <= ext_bus_pkg::AUX_RESET;
      prdata_r     <= 32'h0;
    end else begin
      if (apbSetup) begin
        prdata_r <= prdata_nxt;
      end
      if (apbWrite && hitPort0) begin
        port0Latch_r <= pwdata[7:0];
      end
      if (apbWrite && hitAux) begin
        aux_r <= pwdata[ext_bus_pkg::AUX_WIDTH-1:0];
      end
    end
  end

  // strap is caught on the first edge after reset release
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strapDone_r <= 1'b0;
      extSel_r    <= 1'b1;
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      extSel_r    <= extAccessSelect;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r    <= ext_bus_pkg::BUS_IDLE;
      accWrite_r <= 1'b0;
      accWide_r  <= 1'b0;
      accAddr_r  <= 16'h0;
      accWdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (acceptReq) begin
        accWrite_r <= memWrite;
        accWide_r  <= memWide;
        accAddr_r  <= memAddr;
        accWdata_r <= memWdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ale_r      <= 1'b0;
      psenN_r    <= 1'b1;
      rdN_r      <= 1'b1;
      wrN_r      <= 1'b1;
      p0Out_r    <= 8'h00;
      p0Oe_r     <= 8'h00;
      p2Out_r    <= 8'hFF;
      memRdata_r <= 8'h00;
      memAck_r   <= 1'b0;
    end else begin
      ale_r    <= aleWant;
      psenN_r  <= ~psenWant;
      rdN_r    <= ~rdWant;
      wrN_r    <= ~wrWant;
      p0Out_r  <= p0Out_nxt;
      p0Oe_r   <= p0Oe_nxt;
      p2Out_r  <= p2Out_nxt;
      memAck_r <= readDone;
      if (readDone && !accWrite_r) begin
        memRdata_r <= port0In;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_prog_read_strobe_internal: assert property (
    !extExec |=> progReadStrobeN)
    else $error("program read strobe active on internal execution");

  a_prog_read_strobe_twice: assert property (
    extExec && inIdle && ph == 3'h2 |=>
    !progReadStrobeN ##1 progReadStrobeN ##1 !progReadStrobeN)
    else $error("program read strobe not twice per cycle");

  a_prog_read_strobe_skip: assert property (
    inAcc1 && (ph == 3'h2 || ph == 3'h4) |=> progReadStrobeN)
    else $error("program read strobe not skipped during access");

  a_ale_period: assert property (
    !suppress && inIdle && ph == 3'h0 |=>
    addrLatchStrobe ##1 !addrLatchStrobe [*5])
    else $error("latch strobe not once per machine cycle");

  a_ale_skip: assert property (
    inAcc2 && ph == 3'h0 |=> !addrLatchStrobe)
    else $error("latch strobe not dropped in data half");

  a_ale_suppress: assert property (
    suppress && !inAcc1 |=> !addrLatchStrobe)
    else $error("latch strobe outside data move while suppressed");

  a_rd_window: assert property (
    inAcc1 && ph == 3'h2 && !accWrite_r |=>
    (!rdStrobeN && wrStrobeN) [*6] ##1 rdStrobeN)
    else $error("read strobe not low for six clocks");

  a_wr_window: assert property (
    inAcc1 && ph == 3'h2 && accWrite_r |=>
    (!wrStrobeN && rdStrobeN && port0Oe == 8'hFF) [*6] ##1 wrStrobeN)
    else $error("write strobe not low for six clocks");

  a_strap_frozen: assert property (
    strapDone_r |=> $stable(extSel_r) && strapDone_r)
    else $error("external access select changed after reset");

  a_aux_reserved: assert property (
    apbSetup && hitAux |=> prdata[31:2] == 30'h0)
    else $error("reserved aux bits read nonzero");

  a_reset_values: assert property (
    !strapDone_r |-> port0Latch_r == 8'hFF && aux_r == 2'h0)
    else $error("registers wrong after reset");

  a_port2_high: assert property (
    inAcc1 && accWide_r |=> port2Out == $past(accAddr_r[15:8]))
    else $error("port 2 lacks high address during access");

  c_read_access: cover property (
    inAcc1 && !accWrite_r ##[1:12] memAck);
  c_write_access: cover property (
    inAcc1 && accWrite_r ##[1:12] inIdle);
  c_suppressed_ale: cover property (
    suppress && addrLatchStrobe);
  c_ext_fetch: cover property (
    extExec && !progReadStrobeN);

endmodule

// *** ext_mem_model.sv ***
// external program and data memory with address latch, far side of the bus
module ext_mem_model (
  input  wire logic       sys_clk,
  input  wire logic       addrLatchStrobe,
  input  wire logic       progReadStrobeN,
  input  wire logic       rdStrobeN,
  input  wire logic       wrStrobeN,
  input  wire logic [7:0] port0Out,
  input  wire logic [7:0] port0Oe,
  input  wire logic [7:0] port2Out,
  output logic      [7:0] port0In
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [256];
  logic [7:0] lowAddr;
  logic [7:0] highAddr;
  logic [7:0] lastPin;
  logic       driving;

  //////////////////////////////////////////////////////////////////////////
  assign driving = !rdStrobeN || !progReadStrobeN;
  // no pull-up on port 0: a floating bit shows the inverse of its last level
  assign port0In = (port0Oe & port0Out)
                 | (~port0Oe & (driving ? mem[lowAddr] : ~lastPin));

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
    lowAddr = 8'h00;
    highAddr = 8'h00;
    lastPin = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    lastPin <= port0In;
    if (addrLatchStrobe === 1'b1) begin
      lowAddr <= port0In;
      highAddr <= port2Out;
    end
    if (wrStrobeN === 1'b0) begin
      mem[lowAddr] <= port0In;
    end
  end
endmodule

// *** tb.sv ***
// self-checking bench for the external bus strobe controller
`define CMP(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] rd;
    logic        err;
  } apb_row_type;

  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        extAccessSelect, memReq, memWrite, memWide, memAck, errv;
  logic [15:0] fetchAddr, memAddr;
  logic [7:0]  memWdata, memRdata, port0Out, port0Oe, port0In, port2Out;
  logic [7:0]  hiSeen;
  logic        addrLatchStrobe, progReadStrobeN, rdStrobeN, wrStrobeN;
  logic        extDataRamSelect, extExecActive;
  int          n_errors, n_compared, aleCnt, psenCnt, wrCnt, aD, pD, wD;
  apb_row_type rows [8];

  ext_bus_strobe_ctrl i_ext_bus_strobe_ctrl (.sys_clk(sys_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extAccessSelect(extAccessSelect), .fetchAddr(fetchAddr),
    .memReq(memReq), .memWrite(memWrite), .memWide(memWide),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck), .addrLatchStrobe(addrLatchStrobe),
    .progReadStrobeN(progReadStrobeN), .rdStrobeN(rdStrobeN),
    .wrStrobeN(wrStrobeN), .port0Out(port0Out), .port0Oe(port0Oe),
    .port0In(port0In), .port2Out(port2Out),
    .extDataRamSelect(extDataRamSelect), .extExecActive(extExecActive));

  ext_mem_model i_ext_mem_model (.sys_clk(sys_clk),
    .addrLatchStrobe(addrLatchStrobe), .progReadStrobeN(progReadStrobeN),
    .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN), .port0Out(port0Out),
    .port0Oe(port0Oe), .port2Out(port2Out), .port0In(port0In));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // strobe active-clock counters, sampled mid-cycle where registered pins are settled
  always @(negedge sys_clk) begin
    if (addrLatchStrobe === 1'b1) aleCnt++;
    if (progReadStrobeN === 1'b0) psenCnt++;
    if (wrStrobeN === 1'b0) wrCnt++;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic doReset(input logic strap);
    reset <= 1'b1;
    extAccessSelect <= strap;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // request held until the edge that samples pready high
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // 60-clock window, optionally holding one data move inside it
  task automatic window(input logic acc, input logic w,
                        input logic [15:0] a, input logic [7:0] d);
    int k = 0;
    int a0, p0, w0;
    @(posedge sys_clk);
    a0 = aleCnt;
    p0 = psenCnt;
    w0 = wrCnt;
    if (acc) begin
      memReq <= 1'b1;
      memWrite <= w;
      memAddr <= a;
      memWdata <= d;
      do begin
        @(negedge sys_clk);
        k++;
      end while (memAck !== 1'b1 && k < 40);
      if (memAck !== 1'b1) begin
        n_errors++;
        tally_and_finish();
      end
      // high address as latched for this access, before idle strobes
      hiSeen = i_ext_mem_model.highAddr;
      @(posedge sys_clk);
      memReq <= 1'b0;
    end
    repeat (60 - k) @(negedge sys_clk);
    @(posedge sys_clk);
    aD = aleCnt - a0;
    pD = psenCnt - p0;
    wD = wrCnt - w0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, memReq, memWrite} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    memWide = 1'b1;
    memAddr = 16'h0000;
    memWdata = 8'h00;
    fetchAddr = 16'h8000;
    extAccessSelect = 1'b1;
    n_errors = 0;
    n_compared = 0;
    rows = '{'{0, ext_bus_pkg::PORT0_ADDR, 32'h0, 32'hFF, 0},
             '{0, ext_bus_pkg::AUX_ADDR, 32'h0, 32'h00, 0},
             '{1, ext_bus_pkg::AUX_ADDR, 32'h3, 32'h0, 0},
             '{0, ext_bus_pkg::AUX_ADDR, 32'h0, 32'h03, 0},
             '{1, ext_bus_pkg::PORT0_ADDR, 32'h5A, 32'h0, 0},
             '{0, ext_bus_pkg::PORT0_ADDR, 32'h0, 32'h5A, 0},
             '{0, 12'h004, 32'h0, 32'h00, 1},
             '{1, ext_bus_pkg::AUX_ADDR, 32'h0, 32'h0, 0}};
    doReset(1'b1);
    `CMP(extExecActive, 1'b0)
    for (int i = 0; i < 8; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) `CMP(rdv, rows[i].rd)
      `CMP(errv, rows[i].err)
    end
    apb(1'b1, ext_bus_pkg::AUX_ADDR, 32'h2);
    @(negedge sys_clk);
    `CMP(extDataRamSelect, 1'b1)
    `CMP(port0Oe, 8'hA5)
    apb(1'b1, ext_bus_pkg::AUX_ADDR, 32'h0);
    window(1'b0, 1'b0, 16'h0, 8'h0);
    `CMP(aD, 10)
    `CMP(pD, 0)
    window(1'b1, 1'b0, 16'h1234, 8'h0);
    `CMP(aD, 9)
    `CMP(memRdata, 8'h34 ^ 8'hA5)
    `CMP(hiSeen, 8'h12)
    window(1'b1, 1'b1, 16'h0056, 8'h3C);
    `CMP(i_ext_mem_model.mem[8'h56], 8'h3C)
    `CMP(wD, ext_bus_pkg::CLKS_PER_CYCLE)
    apb(1'b1, ext_bus_pkg::AUX_ADDR, 32'h1);
    window(1'b0, 1'b0, 16'h0, 8'h0);
    `CMP(aD, 0)
    window(1'b1, 1'b0, 16'h0077, 8'h0);
    `CMP(aD, 1)
    doReset(1'b0);
    extAccessSelect <= 1'b1;
    apb(1'b0, ext_bus_pkg::AUX_ADDR, 32'h0);
    `CMP(rdv, 32'h0)
    `CMP(extExecActive, 1'b1)
    window(1'b0, 1'b0, 16'h0, 8'h0);
    `CMP(pD, 20)
    window(1'b1, 1'b0, 16'h0010, 8'h0);
    `CMP(pD, 18)
    `CMP(memRdata, 8'h10 ^ 8'hA5)
    tally_and_finish();
  end
endmodule
